/* rtl/gpio_temp_fault_map.vh */
`ifndef GPIO_TEMP_FAULT_MAP_VH
`define GPIO_TEMP_FAULT_MAP_VH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define OFS_CTRL        8'h00
`define OFS_CMD         8'h04
`define OFS_CELL_MASK   8'h08
`define OFS_TEMP_TEST   8'h0C
`define OFS_TEMP_LIMIT  8'h10
`define OFS_PIN1_MASK   8'h14
`define OFS_STATUS      8'h18
`define OFS_CELL_FAULT  8'h1C
`define OFS_PIN1_DATA   8'h20
`define OFS_PIN2_DATA   8'h24

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define CTRL_P1_DIR     0
`define CTRL_P2_DIR     1
`define CTRL_P1_FUNC    2
`define CTRL_P2_FEN     3
`define CTRL_P2_CODE_LO 4
`define CTRL_P2_CODE_HI 7
`define CTRL_P1_LEVEL   8
`define CTRL_P2_LEVEL   9
`define CTRL_RST        10'h300

// Command register bits
`define CMD_HARD        0
`define CMD_SOFT        1

// Second pin function codes
`define P2_CODE_PULSE   4'h1
`define P2_CODE_SCAN    4'h2

// Status register fields
`define ST_OT_HI        5
`define ST_SUMMARY      6
`define ST_REF_FAULT    7
`define ST_REF_CHECK    8
`define ST_P1_PIN       9
`define ST_P2_PIN       10

// ----------------------------------------------------------------
// Measurement and timing
// ----------------------------------------------------------------
`define OPEN_THRESH     14'h3E00
`define TEMP_LIMIT_RST  14'h0000
`define CH_PIN1         3'h4
`define CH_PIN2         3'h5
`define CLK_MHZ         250
`define CONV_PULSE_NS   5000
`define CONV_PULSE_CYC  ((`CONV_PULSE_NS * `CLK_MHZ + 999) / 1000)
`define REF_DELAY_MS    20
`define REF_DELAY_CYC   (`REF_DELAY_MS * `CLK_MHZ * 1000)
`define HARD_HOLD_CYC   16

`endif

/* rtl/pin_sync3.v */
`timescale 1ns/1ps

// Three-stage pin synchroniser; a change counts once stages two
// and three agree.
module pin_sync3 #(
    parameter         W    = 1,
    parameter [W-1:0] INIT = {W{1'b0}}
) (
    // Clock and reset
    input  wire         clk,
    input  wire         sys_rst,
    // Pin side
    input  wire [W-1:0] d,
    // Filtered level
    output reg  [W-1:0] q
);

    reg [W-1:0] stage1;
    reg [W-1:0] stage2;
    reg [W-1:0] stage3;

    // Capture chain and agreement filter
    always @(posedge clk) begin
        if (sys_rst) begin
            stage1 <= INIT;
            stage2 <= INIT;
            stage3 <= INIT;
            q      <= INIT;
        end else begin
            stage1 <= d;
            stage2 <= stage1;
            stage3 <= stage2;
            q      <= (stage2 & ~(stage2 ^ stage3))
                    | (q & (stage2 ^ stage3));
        end
    end

endmodule

/* rtl/gpio_temp_fault_ctrl.v */
// Overview of operation
// - Cell fault mask hides open-wire and undervoltage faults; voltage still reported.
// - Enable pin pulled high internally; low level from outside resets device.
// - Hard reset command drives enable low, resetting all but sleep regulators.
// - Hard and soft reset commands return every register to default.
// - Reference power-good checked from 20 ms after power-up, enable rise, wake.
// - Temperature input pull-ups connect only while thermistor bias is active.
// - Reading above 31/32 full scale with test enabled sets over-temperature fault.
// - Reading below temperature limit sets the same over-temperature fault.
// - Pins in input mode join every temperature scan.
// - Pins in output mode are open drain, level from register or function.
// - Direction bit 0 means input with pull-up, 1 output without.
// - Input-mode pull-up enabled only during a temperature scan.
// - Output-mode pin data register not updated during conversions.
// - Multiple-register reads skip a pin data register in output mode.
// - Secondary fault mode pulls pin one active on any masked fault.
// - Pulse mode gives pin two a pulse at each conversion start.
// - Scan-level mode holds pin two high during a voltage scan.
// - Host sets each output pin level independently.
// - Function code 1 selects 5 us pulse, 2 scan level, else plain.
// - Pin one function bit 0 plain output, 1 secondary fault.
`timescale 1ns/1ps
`include "gpio_temp_fault_map.vh"

module gpio_temp_fault_ctrl #(
    parameter REF_DELAY_CYC = `REF_DELAY_CYC
) (
    // Clock and reset
    input  wire        clk,
    input  wire        sys_rst,
    // Wishbone slave
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    // Commands from the chain decoder
    input  wire        hard_reset_cmd,
    input  wire        soft_reset_cmd,
    input  wire        wake_done,
    // Enable pin
    input  wire        en_pin_i,
    output wire        en_pin_o,
    output reg         en_pin_oe,
    output wire        en_pin_pu,
    output wire        block_rst,
    // Reference power-good comparator
    input  wire        ref_good_i,
    // Scan sequencer
    input  wire        scan_temp_active,
    input  wire        scan_volt_active,
    input  wire        conv_start,
    input  wire        conv_valid,
    input  wire [2:0]  conv_chan,
    input  wire [13:0] conv_data,
    output wire [1:0]  scan_pin_include,
    output wire [1:0]  multi_read_skip,
    // Thermistor bias and pull-ups
    output reg         thermistor_bias_out,
    output reg  [3:0]  ext_temp_pu,
    // Cell faults
    input  wire [13:0] cell_open_raw,
    input  wire [13:0] cell_uv_raw,
    output reg  [13:0] cell_fault,
    input  wire [15:0] fault_vec,
    // Auxiliary pins
    input  wire        aux_pin_one_i,
    output wire        aux_pin_one_o,
    output reg         aux_pin_one_oe,
    output reg         aux_pin_one_pu,
    input  wire        aux_pin_two_i,
    output wire        aux_pin_two_o,
    output reg         aux_pin_two_oe,
    output reg         aux_pin_two_pu,
    // Status
    output wire        over_temp_summary_flag,
    output wire        ref_fault
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    wire [3:0] pins_s;

    pin_sync3 #(
        .W    (4),
        .INIT (4'hF)
    ) u_sync (
        .clk     (clk),
        .sys_rst (sys_rst),
        .d       ({aux_pin_two_i, aux_pin_one_i, ref_good_i, en_pin_i}),
        .q       (pins_s)
    );

    wire en_s   = pins_s[0];
    wire ref_s  = pins_s[1];
    wire p1_s   = pins_s[2];
    wire p2_s   = pins_s[3];

    // ------------------------------------------------------------
    // Enable pin and hard reset
    // ------------------------------------------------------------
    reg  [4:0] hard_cnt;
    reg        en_prev;
    reg        reg_rst;
    wire       cmd_hard;
    wire       cmd_soft;

    assign en_pin_o  = 1'b0;
    assign en_pin_pu = 1'b1;
    assign block_rst = sys_rst | ~en_s | en_pin_oe;

    // Hold enable low for a fixed time after a hard reset command
    always @(posedge clk) begin
        if (sys_rst) begin
            hard_cnt  <= 5'h00;
            en_pin_oe <= 1'b0;
        end else if (cmd_hard) begin
            hard_cnt  <= 5'h00;
            en_pin_oe <= 1'b1;
        end else if (en_pin_oe) begin
            hard_cnt  <= hard_cnt + 5'h01;
            if (hard_cnt == `HARD_HOLD_CYC - 1)
                en_pin_oe <= 1'b0;
        end
    end

    // Register reset: power-on, enable low, either command
    always @(posedge clk) begin
        if (sys_rst)
            reg_rst <= 1'b1;
        else
            reg_rst <= block_rst | cmd_hard | cmd_soft;
    end

    // ------------------------------------------------------------
    // Reference power-good check
    // ------------------------------------------------------------
    reg [22:0] ref_cnt;
    reg        ref_check;
    reg        ref_flt;
    wire       ref_start = (en_s & ~en_prev) | wake_done;

    assign ref_fault = ref_flt;

    // Delay then continuous check; restarted by enable rise or wake
    always @(posedge clk) begin
        if (sys_rst) begin
            en_prev   <= 1'b1;
            ref_cnt   <= 23'h000000;
            ref_check <= 1'b0;
        end else begin
            en_prev <= en_s;
            if (ref_start) begin
                ref_cnt   <= 23'h000000;
                ref_check <= 1'b0;
            end else if (!ref_check) begin
                ref_cnt <= ref_cnt + 23'h000001;
                if (ref_cnt == REF_DELAY_CYC - 1)
                    ref_check <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    reg  [9:0]  ctrl;
    reg  [13:0] cell_mask;
    reg  [5:0]  temp_test;
    reg  [13:0] temp_limit;
    reg  [15:0] pin1_mask;
    reg  [5:0]  ot_fault;
    reg  [13:0] pin1_data;
    reg  [13:0] pin2_data;

    wire        bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire        wr      = bus_req & wb_we_i;
    wire [15:0] wmask   = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wire [15:0] wdat    = wb_dat_i[15:0];
    wire [15:0] st_word;

    assign cmd_hard = hard_reset_cmd
                    | (wr & (wb_adr_i == `OFS_CMD) & wb_sel_i[0]
                       & wb_dat_i[`CMD_HARD]);
    assign cmd_soft = soft_reset_cmd
                    | (wr & (wb_adr_i == `OFS_CMD) & wb_sel_i[0]
                       & wb_dat_i[`CMD_SOFT]);

    wire       p1_dir  = ctrl[`CTRL_P1_DIR];
    wire       p2_dir  = ctrl[`CTRL_P2_DIR];
    wire [3:0] p2_code = ctrl[`CTRL_P2_CODE_HI:`CTRL_P2_CODE_LO];
    wire       p2_fen  = ctrl[`CTRL_P2_FEN];

    // Host-written configuration with byte lanes
    always @(posedge clk) begin
        if (reg_rst) begin
            ctrl       <= `CTRL_RST;
            cell_mask  <= 14'h0000;
            temp_test  <= 6'h00;
            temp_limit <= `TEMP_LIMIT_RST;
            pin1_mask  <= 16'h0000;
        end else if (wr) begin
            if (wb_adr_i == `OFS_CTRL)
                ctrl <= (ctrl & ~wmask[9:0]) | (wdat[9:0] & wmask[9:0]);
            else if (wb_adr_i == `OFS_CELL_MASK)
                cell_mask <= (cell_mask & ~wmask[13:0])
                           | (wdat[13:0] & wmask[13:0]);
            else if (wb_adr_i == `OFS_TEMP_TEST)
                temp_test <= (temp_test & ~wmask[5:0])
                           | (wdat[5:0] & wmask[5:0]);
            else if (wb_adr_i == `OFS_TEMP_LIMIT)
                temp_limit <= (temp_limit & ~wmask[13:0])
                            | (wdat[13:0] & wmask[13:0]);
            else if (wb_adr_i == `OFS_PIN1_MASK)
                pin1_mask <= (pin1_mask & ~wmask) | (wdat & wmask);
        end
    end

    // ------------------------------------------------------------
    // Temperature conversions and faults
    // ------------------------------------------------------------
    wire [5:0] ch_hit   = 6'h01 << conv_chan;
    wire       is_open  = conv_data > `OPEN_THRESH;
    wire       is_hot   = conv_data < temp_limit;
    wire       ch_ok    = conv_valid & (conv_chan < 3'h6);
    wire [5:0] ot_set   = (ch_ok & (is_open | is_hot))
                        ? (ch_hit & temp_test) : 6'h00;
    wire [5:0] ot_clr   = (wr & (wb_adr_i == `OFS_STATUS) & wb_sel_i[0])
                        ? wdat[5:0] : 6'h00;
    wire       rf_clr   = wr & (wb_adr_i == `OFS_STATUS) & wb_sel_i[0]
                        & wdat[`ST_REF_FAULT];

    assign over_temp_summary_flag = |ot_fault;

    // Sticky faults; a new event wins over a clear
    always @(posedge clk) begin
        if (reg_rst) begin
            ot_fault <= 6'h00;
            ref_flt  <= 1'b0;
        end else begin
            ot_fault <= (ot_fault & ~ot_clr) | ot_set;
            ref_flt  <= (ref_flt & ~rf_clr)
                      | (ref_check & ~ref_s);
        end
    end

    // Pin data registers frozen while the pin is an output
    always @(posedge clk) begin
        if (reg_rst) begin
            pin1_data <= 14'h0000;
            pin2_data <= 14'h0000;
        end else if (conv_valid) begin
            if (conv_chan == `CH_PIN1 && !p1_dir)
                pin1_data <= conv_data;
            if (conv_chan == `CH_PIN2 && !p2_dir)
                pin2_data <= conv_data;
        end
    end

    assign scan_pin_include = {~p2_dir, ~p1_dir};
    assign multi_read_skip  = {p2_dir, p1_dir};

    // Cell fault masking and thermistor bias
    always @(posedge clk) begin
        if (reg_rst) begin
            cell_fault          <= 14'h0000;
            thermistor_bias_out <= 1'b0;
            ext_temp_pu         <= 4'h0;
        end else begin
            cell_fault <= (cell_open_raw | cell_uv_raw) & ~cell_mask;
            thermistor_bias_out <= scan_temp_active;
            ext_temp_pu <= {4{thermistor_bias_out}};
        end
    end

    // ------------------------------------------------------------
    // Auxiliary pin output functions
    // ------------------------------------------------------------
    reg  [10:0] pulse_cnt;
    reg         pulse_on;
    wire        p2_pulse_mode = p2_fen & (p2_code == `P2_CODE_PULSE);
    wire        p2_scan_mode  = p2_fen & (p2_code == `P2_CODE_SCAN);
    wire        p1_fault_on   = |(fault_vec & pin1_mask);
    reg         next_p1_level;
    reg         next_p2_level;

    // Conversion-start pulse timer
    always @(posedge clk) begin
        if (reg_rst) begin
            pulse_cnt <= 11'h000;
            pulse_on  <= 1'b0;
        end else if (conv_start && p2_pulse_mode) begin
            pulse_cnt <= 11'h000;
            pulse_on  <= 1'b1;
        end else if (pulse_on) begin
            pulse_cnt <= pulse_cnt + 11'h001;
            if (pulse_cnt == `CONV_PULSE_CYC - 1)
                pulse_on <= 1'b0;
        end
    end

    // Output level selection; level 0 pulls the pin low
    always @* begin
        if (ctrl[`CTRL_P1_FUNC])
            next_p1_level = ~p1_fault_on;
        else
            next_p1_level = ctrl[`CTRL_P1_LEVEL];
        if (p2_pulse_mode)
            next_p2_level = pulse_on;
        else if (p2_scan_mode)
            next_p2_level = scan_volt_active;
        else
            next_p2_level = ctrl[`CTRL_P2_LEVEL];
    end

    assign aux_pin_one_o = 1'b0;
    assign aux_pin_two_o = 1'b0;

    // Open-drain drive and input pull-ups
    always @(posedge clk) begin
        if (reg_rst) begin
            aux_pin_one_oe <= 1'b0;
            aux_pin_two_oe <= 1'b0;
            aux_pin_one_pu <= 1'b0;
            aux_pin_two_pu <= 1'b0;
        end else begin
            aux_pin_one_oe <= p1_dir & ~next_p1_level;
            aux_pin_two_oe <= p2_dir & ~next_p2_level;
            aux_pin_one_pu <= ~p1_dir & scan_temp_active;
            aux_pin_two_pu <= ~p2_dir & scan_temp_active;
        end
    end

    // ------------------------------------------------------------
    // Wishbone answer
    // ------------------------------------------------------------
    assign st_word = {5'h00, p2_s, p1_s, ref_check, ref_flt,
                      over_temp_summary_flag, ot_fault};

    always @(posedge clk) begin
        if (sys_rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= bus_req;
            if (bus_req && !wb_we_i) begin
                if (wb_adr_i == `OFS_CTRL)
                    wb_dat_o <= {22'h000000, ctrl};
                else if (wb_adr_i == `OFS_CELL_MASK)
                    wb_dat_o <= {18'h00000, cell_mask};
                else if (wb_adr_i == `OFS_TEMP_TEST)
                    wb_dat_o <= {26'h0000000, temp_test};
                else if (wb_adr_i == `OFS_TEMP_LIMIT)
                    wb_dat_o <= {18'h00000, temp_limit};
                else if (wb_adr_i == `OFS_PIN1_MASK)
                    wb_dat_o <= {16'h0000, pin1_mask};
                else if (wb_adr_i == `OFS_STATUS)
                    wb_dat_o <= {16'h0000, st_word};
                else if (wb_adr_i == `OFS_CELL_FAULT)
                    wb_dat_o <= {18'h00000, cell_fault};
                else if (wb_adr_i == `OFS_PIN1_DATA)
                    wb_dat_o <= {18'h00000, pin1_data};
                else if (wb_adr_i == `OFS_PIN2_DATA)
                    wb_dat_o <= {18'h00000, pin2_data};
                else
                    wb_dat_o <= 32'h00000000;
            end
        end
    end

endmodule

/* testbench/gpio_temp_fault_chk.sv */
`timescale 1ns/1ps

// Port-level checker for the pin, reset and temperature logic
module gpio_temp_fault_chk #(
    parameter REF_DELAY_CYC = 200
) (
    // Clock and reset
    input wire       clk,
    input wire       sys_rst,
    // Bus handshake
    input wire       wb_cyc_i,
    input wire       wb_stb_i,
    input wire       wb_ack_o,
    // Enable pin and commands
    input wire       hard_reset_cmd,
    input wire       en_pin_o,
    input wire       en_pin_oe,
    input wire       en_pin_pu,
    input wire       block_rst,
    // Scan and conversions
    input wire       scan_temp_active,
    input wire       conv_valid,
    input wire [1:0] scan_pin_include,
    input wire [1:0] multi_read_skip,
    input wire [3:0] ext_temp_pu,
    // Auxiliary pins and status
    input wire       aux_pin_one_o,
    input wire       aux_pin_one_oe,
    input wire       aux_pin_one_pu,
    input wire       aux_pin_two_o,
    input wire       aux_pin_two_oe,
    input wire       aux_pin_two_pu,
    input wire       over_temp_summary_flag
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    // Bus answer one cycle after a request, one cycle wide
    property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
    a_ack: assert property (p_ack) else $error("ack late");
    property p_ack_one; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_one: assert property (p_ack_one) else $error("ack too long");
    // Enable pin held up, pulled low on hard command
    property p_en_pu; en_pin_pu && !en_pin_o; endproperty
    a_en_pu: assert property (p_en_pu) else $error("enable pull-up lost");
    property p_hard; hard_reset_cmd |=> en_pin_oe [*8]; endproperty
    a_hard: assert property (p_hard) else $error("enable not pulled");
    property p_blk; en_pin_oe |-> block_rst; endproperty
    a_blk: assert property (p_blk) else $error("blocks not in reset");
    // Pins are open drain only
    property p_od; !aux_pin_one_o && !aux_pin_two_o; endproperty
    a_od: assert property (p_od) else $error("pin driven high");
    // Scanned pins are exactly those not skipped
    property p_skip; scan_pin_include == ~multi_read_skip; endproperty
    a_skip: assert property (p_skip) else $error("skip mismatch");
    // No pull-up while a pin drives
    property p_pu; !(aux_pin_one_pu && aux_pin_one_oe) &&
        !(aux_pin_two_pu && aux_pin_two_oe); endproperty
    a_pu: assert property (p_pu) else $error("pull-up on output");
    // Input pull-ups follow the bias two cycles after scan start
    property p_bias; $rose(scan_temp_active) |-> ##2 ext_temp_pu == 4'hF;
    endproperty
    a_bias: assert property (p_bias) else $error("pull-ups off");
    // Summary flag rises only from a conversion
    property p_ot; $rose(over_temp_summary_flag) |-> $past(conv_valid);
    endproperty
    a_ot: assert property (p_ot) else $error("flag without conversion");
endmodule

/* testbench/ext_pin_model.sv */
`timescale 1ns/1ps

// Outside circuits on the enable and auxiliary pins
module ext_pin_model (
    // Device side
    input  wire en_pin_o,
    input  wire en_pin_oe,
    input  wire aux_pin_one_o,
    input  wire aux_pin_one_oe,
    input  wire aux_pin_two_o,
    input  wire aux_pin_two_oe,
    // Outside party grounding enable
    input  wire ext_en_low,
    // Wire levels
    output wire en_pin_i,
    output wire aux_pin_one_i,
    output wire aux_pin_two_i
);
    // Enable pulled up unless device or outside pulls it down
    assign en_pin_i = !(en_pin_oe && !en_pin_o) && !ext_en_low;
    // Open-drain pins with external pull-ups
    assign aux_pin_one_i = !(aux_pin_one_oe && !aux_pin_one_o);
    assign aux_pin_two_i = !(aux_pin_two_oe && !aux_pin_two_o);
endmodule

/* testbench/gpio_temp_fault_ctrl_tb.sv */
`timescale 1ns/1ps
`include "gpio_temp_fault_map.vh"

module gpio_temp_fault_ctrl_tb;
    reg         clk, sys_rst, wb_cyc_i, wb_stb_i, wb_we_i, ext_en_low;
    reg  [7:0]  wb_adr_i;
    reg  [3:0]  wb_sel_i;
    reg  [31:0] wb_dat_i, q, r, m, o, u;
    reg         hard_reset_cmd, soft_reset_cmd, wake_done, ref_good_i;
    reg         scan_temp_active, scan_volt_active, conv_start, conv_valid;
    reg  [2:0]  conv_chan;
    reg  [13:0] conv_data, cell_open_raw, cell_uv_raw;
    reg  [15:0] fault_vec;
    wire [31:0] wb_dat_o;
    wire        wb_ack_o, en_pin_i, en_pin_o, en_pin_oe, en_pin_pu, block_rst;
    wire        thermistor_bias_out, over_temp_summary_flag, ref_fault;
    wire        aux_pin_one_i, aux_pin_one_o, aux_pin_one_oe, aux_pin_one_pu;
    wire        aux_pin_two_i, aux_pin_two_o, aux_pin_two_oe, aux_pin_two_pu;
    wire [1:0]  scan_pin_include, multi_read_skip;
    wire [3:0]  ext_temp_pu;
    wire [13:0] cell_fault;
    integer     num_errors, check_count, j, n, cyc_cnt;

    gpio_temp_fault_ctrl #(.REF_DELAY_CYC(200)) u_gpio_temp_fault_ctrl (.*);
    ext_pin_model u_ext_pin_model (.*);

    // Clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Hang guard
    always @(posedge clk) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 20000) begin
            num_errors = num_errors + 1;
            conclude;
        end
    end

    task tick(input integer k);
        repeat (k) @(posedge clk);
    endtask
    task chk(input string nm, input [31:0] seen, input [31:0] exp);
        check_count = check_count + 1;
        if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // One classic bus cycle; read data lands in q
    task wb(input w, input [7:0] a, input [31:0] d);
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do @(posedge clk); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk);
    endtask
    task conv(input [2:0] c, input [13:0] d);
        conv_chan <= c;
        conv_data <= d;
        conv_valid <= 1'b1;
        tick(1);
        conv_valid <= 1'b0;
        tick(1);
    endtask
    task conclude;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Main sequence
    initial begin
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, ext_en_low} = 0;
        {hard_reset_cmd, soft_reset_cmd, wake_done, conv_start} = 0;
        {scan_temp_active, scan_volt_active, conv_valid, conv_chan} = 0;
        {conv_data, cell_open_raw, cell_uv_raw, fault_vec} = 0;
        {num_errors, check_count, cyc_cnt} = 0;
        wb_sel_i = 4'h3;
        ref_good_i = 1'b1;
        sys_rst = 1'b1;
        void'($urandom(92207));
        tick(20);
        sys_rst <= 1'b0;
        tick(2);
        wb(0, `OFS_CTRL, 0);
        chk("ctrl", q, 32'h300);
        wb(0, 8'h3C, 0);
        chk("unmapped", q, 0);
        $display("test defaults done");
        for (j = 0; j < 8; j = j + 1) begin
            r = $urandom % 32;
            scan_temp_active <= r[4];
            wb(1, `OFS_CTRL, {22'h0, r[3:2], 6'h0, r[1:0]});
            tick(4);
            chk("p1_oe", aux_pin_one_oe, r[0] && !r[2]);
            chk("p2_oe", aux_pin_two_oe, r[1] && !r[3]);
            chk("p1_pu", aux_pin_one_pu, !r[0] && r[4]);
            chk("p2_pu", aux_pin_two_pu, !r[1] && r[4]);
            chk("incl", scan_pin_include, r[1:0] ^ 2'h3);
        end
        $display("test pin modes done");
        wb(1, `OFS_TEMP_TEST, 32'h0B);
        wb(1, `OFS_TEMP_LIMIT, 32'h1000);
        wb(1, `OFS_STATUS, 32'h3F);
        r = $urandom % 32'h1000;
        conv(0, 14'h3E01);
        conv(1, 14'h3E00);
        conv(1, 14'h1000);
        conv(2, 14'h3F00);
        conv(3, r[13:0]);
        wb(0, `OFS_STATUS, 0);
        chk("st_open", q & 32'h43, 32'h41);
        chk("st_limit", q & 32'h0C, 32'h08);
        chk("ot_flag", over_temp_summary_flag, 1);
        wb(1, `OFS_STATUS, 32'h3F);
        wb(0, `OFS_STATUS, 0);
        chk("st_clear", q & 32'h7F, 0);
        wb(1, `OFS_CTRL, 32'h300);
        r = $urandom % 32'h4000;
        conv(4, r[13:0]);
        wb(0, `OFS_PIN1_DATA, 0);
        chk("p1_in", q & 32'h3FFF, r);
        wb(1, `OFS_CTRL, 32'h301);
        conv(4, ~r[13:0]);
        wb(0, `OFS_PIN1_DATA, 0);
        chk("p1_out", q & 32'h3FFF, r);
        chk("skip", multi_read_skip, 2'h1);
        $display("test temperature done");
        for (j = 0; j < 4; j = j + 1) begin
            m = (j == 0) ? 32'h3FFF : $urandom % 32'h4000;
            o = $urandom % 32'h4000;
            u = $urandom % 32'h4000;
            wb(1, `OFS_CELL_MASK, m);
            cell_open_raw <= o[13:0];
            cell_uv_raw <= u[13:0];
            tick(3);
            chk("cell", cell_fault, (o | u) & ~m);
        end
        m = 32'h1 << ($urandom % 16);
        wb(1, `OFS_PIN1_MASK, m);
        wb(1, `OFS_CTRL, 32'h105);
        for (j = 0; j < 3; j = j + 1) begin
            fault_vec <= (j == 0) ? m[15:0] : (j == 1) ? ~m[15:0] : 16'h0;
            tick(3);
            chk("p1_fault", aux_pin_one_oe, j == 0);
        end
        fault_vec <= m[15:0];
        wb(1, `OFS_CTRL, 32'h101);
        tick(2);
        chk("p1_plain", aux_pin_one_oe, 0);
        $display("test faults done");
        for (j = 0; j < 5; j = j + 1) begin
            wb(1, `OFS_CTRL, (j == 4) ? 32'h212 : 32'h20A | (j << 4));
            conv_start <= 1'b1;
            tick(1);
            conv_start <= 1'b0;
            n = 0;
            repeat (1300) begin
                tick(1);
                if (aux_pin_two_oe === 1'b0)
                    n = n + 1;
            end
            chk("p2_pulse", n, (j == 1) ? `CONV_PULSE_CYC : (j == 2) ? 0 : 1300);
            scan_volt_active <= (j == 2);
            tick(4);
            chk("p2_scan", aux_pin_two_oe, j == 1);
            scan_volt_active <= 1'b0;
        end
        $display("test pin two done");
        for (j = 0; j < 3; j = j + 1) begin
            wb(1, `OFS_CTRL, 32'h0FF);
            if (j == 2)
                wb(1, `OFS_CMD, 32'h2);
            hard_reset_cmd <= (j == 0);
            soft_reset_cmd <= (j == 1);
            tick(1);
            {hard_reset_cmd, soft_reset_cmd} <= 2'h0;
            n = 0;
            repeat (30) begin
                tick(1);
                if (en_pin_oe === 1'b1)
                    n = n + 1;
            end
            chk("en_low", n, (j == 0) ? `HARD_HOLD_CYC : 0);
            wb(0, `OFS_CTRL, 0);
            chk("ctrl_rst", q, 32'h300);
        end
        for (j = 0; j < 2; j = j + 1) begin
            ref_good_i <= 1'b1;
            tick(5);
            wb(1, `OFS_STATUS, 32'h80);
            ext_en_low <= (j == 0);
            wake_done <= (j == 1);
            tick(j == 0 ? 10 : 1);
            if (j == 0)
                chk("blk_rst", block_rst, 1);
            {ext_en_low, wake_done} <= 2'h0;
            ref_good_i <= 1'b0;
            tick(150);
            chk("ref_early", ref_fault, 0);
            tick(80);
            chk("ref_late", ref_fault, 1);
        end
        $display("test resets done");
        conclude;
    end
endmodule

bind gpio_temp_fault_ctrl gpio_temp_fault_chk #(
    .REF_DELAY_CYC(REF_DELAY_CYC)
) u_gpio_temp_fault_chk (
    .clk, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .hard_reset_cmd,
    .en_pin_o, .en_pin_oe, .en_pin_pu, .block_rst, .scan_temp_active,
    .conv_valid, .scan_pin_include, .multi_read_skip, .ext_temp_pu,
    .aux_pin_one_o, .aux_pin_one_oe, .aux_pin_one_pu, .aux_pin_two_o,
    .aux_pin_two_oe, .aux_pin_two_pu, .over_temp_summary_flag);
